// ---- pkg/pafs_pkg.sv ----
// constants and types for the port alternate-function setup block
// assumes an axi4-lite master on aclk and pads resolved outside
//
// Summary of operation
// [R1] each port11_pullup_sel bit 0..3 set to 1 connects its pin pull-up
// [R2] port11_pullup_sel resets to zero, fixed index, bits 7..4 read zero
// [R3] port11_pullup_sel accepts byte and single-bit reads and writes
// [R4] port_alt_ctrl bit 0 turns the wait input on; other bits read zero
// [R5] port_alt_ctrl resets to zero at its fixed index
// [R6] port_alt_ctrl accepts byte and single-bit reads and writes
// [R7] software sets direction and latch per pin before alternate use
// [R8] nmi input on port 0 bit 0 needs input direction only
// [R9] port 0 bit 5 interrupt and converter trigger need input direction
// [R10] port 0 bit 7 interrupt input needs input direction
// [R11] port 1 bit 0 serial data input needs input direction
// [R12] port 1 bit 2 clock: input direction, or output with latch zero
// [R13] port 1 bit 5 clock or baud clock input; output needs latch zero
// [R14] i2c pins need output direction, latch zero, open-drain bit set
// [R15] port 3 bit 4 outputs need output direction and latch zero
// [R16] alternate outputs drive only in output direction; inputs always sampled
// [R17] driven pin shows latch ored with peripheral output
// [R18] only wait_input_enable switches port 11 bit 0 to wait input
`default_nettype none
package pafs_pkg;
  // ------------------------------------------------------------
  // register indices; byte address is four times the index
  // ------------------------------------------------------------
  localparam logic [31:0] IDX_PORT_ALT_CTRL = 32'hffff_f040;
  localparam logic [31:0] IDX_PORT11_PULLUP = 32'hffff_f096;
  localparam logic [31:0] IDX_LATCH_BASE = 32'h0000_0000;
  localparam logic [31:0] IDX_DIR_BASE = 32'h0000_0008;
  localparam logic [31:0] IDX_OD_BASE = 32'h0000_0010;
  localparam logic [31:0] IDX_BIT_BASE = 32'h0000_0100;
  localparam int NPORT = 5;
  localparam int NOD = 2;
  // ------------------------------------------------------------
  // reset values and field positions
  // ------------------------------------------------------------
  localparam logic [7:0] RST_PORT_ALT_CTRL = 8'h00;
  localparam logic [7:0] RST_PORT11_PULLUP = 8'h00;
  localparam logic [7:0] RST_DIR = 8'hff;
  localparam logic [7:0] RST_DIR_P11 = 8'h1f;
  localparam logic [7:0] MASK_P11 = 8'h0f;
  localparam logic [7:0] MASK_PAC = 8'h01;
  localparam int WAIT_EN_BIT = 0;
  localparam int P11_IDX = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    PAFS_K_NONE = 3'b000,
    PAFS_K_LATCH = 3'b001,
    PAFS_K_DIR = 3'b010,
    PAFS_K_OD = 3'b011,
    PAFS_K_PAC = 3'b100,
    PAFS_K_PU = 3'b101,
    PAFS_K_BIT = 3'b110
  } pafs_kind_t;

  typedef struct packed {
    pafs_kind_t kind;
    logic [3:0] idx;
  } pafs_dec_t;

  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
  } pafs_pad_t;
endpackage
`default_nettype wire

// ---- rtl/pafs_sync.sv ----
// two-flop synchroniser for pin inputs
// assumes asynchronous inputs and one clock
`default_nettype none
module pafs_sync #(
  parameter int W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
    end
  end
  assign q = s2_reg;
endmodule
`default_nettype wire

// ---- rtl/pafs_pad.sv ----
// per-port pad steering: latch ored with peripheral, open-drain option
// assumes the caller registers the result
`default_nettype none
module pafs_pad
  import pafs_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic [W-1:0] latch,
  input wire logic [W-1:0] alt,
  input wire logic [W-1:0] dir,
  input wire logic [W-1:0] od,
  output pafs_pad_t pad
);
  logic [W-1:0] val;

  always_comb begin
    val = latch | alt; // R17
    pad = '0;
    // open-drain pulls low only; normal drives both levels
    pad.o = val & ~od;
    pad.oe = ~dir & (~od | ~val); // R16
  end
endmodule
`default_nettype wire

// ---- rtl/pafs_top.sv ----
// port pin setup: latches, directions, open-drain, pull-ups, wait enable
// assumes an axi4-lite master on aclk; pins arrive asynchronously
`default_nettype none
module pafs_top
  import pafs_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NPORT-1:0][7:0] pin_i,
  output logic [NPORT-1:0][7:0] pin_o,
  output logic [NPORT-1:0][7:0] pin_oe,
  input wire logic [NPORT-1:0][7:0] alt_out,
  output logic [NPORT-1:0][7:0] alt_in,
  output logic [3:0] port11_pullup_en,
  output logic ext_wait_req
);
  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  localparam int AW = ADDR_W - 2;

  function automatic logic hit(input logic [AW-1:0] w, input logic [31:0] idx);
    hit = (w == idx[AW-1:0]);
  endfunction

  function automatic pafs_dec_t decode(input logic [ADDR_W-1:0] a);
    logic [AW-1:0] w;
    pafs_dec_t d;
    w = a[ADDR_W-1:2];
    d = '{kind: PAFS_K_NONE, idx: 4'h0};
    for (int i = 0; i < NPORT; i++) begin
      if (hit(w, IDX_LATCH_BASE + 32'(i))) d = '{kind: PAFS_K_LATCH, idx: 4'(i)};
      if (hit(w, IDX_DIR_BASE + 32'(i))) d = '{kind: PAFS_K_DIR, idx: 4'(i)};
    end
    for (int i = 0; i < NOD; i++) begin
      if (hit(w, IDX_OD_BASE + 32'(i))) d = '{kind: PAFS_K_OD, idx: 4'(i)};
    end
    for (int i = 0; i < 16; i++) begin
      if (hit(w, IDX_BIT_BASE + 32'(i))) d = '{kind: PAFS_K_BIT, idx: 4'(i)};
    end
    if (hit(w, IDX_PORT_ALT_CTRL)) d = '{kind: PAFS_K_PAC, idx: 4'h0};
    if (hit(w, IDX_PORT11_PULLUP)) d = '{kind: PAFS_K_PU, idx: 4'h0};
    decode = d;
  endfunction

  function automatic logic [7:0] port_mask(input int p);
    port_mask = (p == P11_IDX) ? MASK_P11 : 8'hff;
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [NPORT-1:0][7:0] latch_reg, latch_next;
  logic [NPORT-1:0][7:0] dir_reg, dir_next;
  logic [NOD-1:0][7:0] od_reg, od_next;
  logic [7:0] pac_reg, pac_next;
  logic [7:0] pu_reg, pu_next;
  logic aw_held_reg, aw_held_next;
  logic w_held_reg, w_held_next;
  logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic wstrb0_reg, wstrb0_next;
  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [NPORT-1:0][7:0] pin_sync;
  logic [NPORT-1:0][7:0] od_full;
  pafs_pad_t [NPORT-1:0] pad;
  logic [NPORT-1:0][7:0] pin_o_reg, pin_oe_reg, alt_in_reg;
  logic [3:0] pu_out_reg;
  logic wait_reg;
  logic do_write;
  pafs_dec_t wdec, rdec;

  // ------------------------------------------------------------
  // pins
  // ------------------------------------------------------------
  pafs_sync #(.W(NPORT * 8)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(pin_i),
    .q(pin_sync)
  );

  always_comb begin
    od_full = '0;
    od_full[1] = od_reg[0]; // R14
    od_full[2] = od_reg[1];
  end

  for (genvar p = 0; p < NPORT; p++) begin : g_pad
    pafs_pad #(.W(8)) u_pad (
      .latch(latch_reg[p]),
      .alt(alt_out[p] & port_mask(p)),
      .dir(dir_reg[p]),
      .od(od_full[p]),
      .pad(pad[p])
    );
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_o_reg <= '0;
      pin_oe_reg <= '0;
      alt_in_reg <= '0;
      pu_out_reg <= '0;
      wait_reg <= 1'b0;
    end else begin
      for (int p = 0; p < NPORT; p++) begin
        pin_o_reg[p] <= pad[p].o; // R17
        pin_oe_reg[p] <= pad[p].oe & port_mask(p); // R16
      end
      alt_in_reg <= pin_sync; // R16
      pu_out_reg <= pu_reg[3:0]; // R1
      // wait pin is active low; only the enable bit gates it
      wait_reg <= pac_reg[WAIT_EN_BIT] & ~pin_sync[P11_IDX][0]; // R18
    end
  end

  // ------------------------------------------------------------
  // axi4-lite write and read
  // ------------------------------------------------------------
  assign wdec = decode(awaddr_reg);
  assign rdec = decode(s_axi_araddr);
  assign do_write = aw_held_reg & w_held_reg & ~bvalid_reg;

  always_comb begin
    logic [7:0] b;
    logic [NPORT-1:0][7:0] rd_port;
    b = wdata_reg[7:0];
    rd_port = '0;
    latch_next = latch_reg;
    dir_next = dir_reg;
    od_next = od_reg;
    pac_next = pac_reg;
    pu_next = pu_reg;
    aw_held_next = aw_held_reg | (s_axi_awvalid & awready_reg);
    w_held_next = w_held_reg | (s_axi_wvalid & wready_reg);
    awaddr_next = (s_axi_awvalid & awready_reg) ? s_axi_awaddr : awaddr_reg;
    wdata_next = (s_axi_wvalid & wready_reg) ? s_axi_wdata : wdata_reg;
    wstrb0_next = (s_axi_wvalid & wready_reg) ? s_axi_wstrb[0] : wstrb0_reg;
    bvalid_next = bvalid_reg & ~s_axi_bready;
    bresp_next = bresp_reg;
    if (do_write) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = (wdec.kind == PAFS_K_NONE) ? RESP_SLVERR : RESP_OKAY;
      if (wstrb0_reg) begin
        case (wdec.kind)
          PAFS_K_LATCH: latch_next[wdec.idx] = b & port_mask(int'(wdec.idx));
          PAFS_K_DIR: dir_next[wdec.idx] = b & port_mask(int'(wdec.idx));
          PAFS_K_OD: od_next[wdec.idx[0]] = b;
          PAFS_K_PAC: pac_next = b & MASK_PAC; // R4 R6
          PAFS_K_PU: pu_next = b & MASK_P11; // R2 R3
          PAFS_K_BIT: begin
            if (wdec.idx[3]) pu_next[wdec.idx[2:0]] = b[0] & MASK_P11[wdec.idx[2:0]]; // R3
            else pac_next[wdec.idx[2:0]] = b[0] & MASK_PAC[wdec.idx[2:0]]; // R6
          end
          default: ;
        endcase
      end
    end
    awready_next = ~aw_held_next & ~bvalid_next;
    wready_next = ~w_held_next & ~bvalid_next;
    for (int p = 0; p < NPORT; p++) begin
      rd_port[p] = (pin_sync[p] & dir_reg[p] | latch_reg[p] & ~dir_reg[p]) & port_mask(p);
    end
    rvalid_next = rvalid_reg & ~s_axi_rready;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_arvalid & arready_reg) begin
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      case (rdec.kind)
        PAFS_K_LATCH: rdata_next = {24'h00_0000, rd_port[rdec.idx]};
        PAFS_K_DIR: rdata_next = {24'h00_0000, dir_reg[rdec.idx]};
        PAFS_K_OD: rdata_next = {24'h00_0000, od_reg[rdec.idx[0]]};
        PAFS_K_PAC: rdata_next = {24'h00_0000, pac_reg};
        PAFS_K_PU: rdata_next = {24'h00_0000, pu_reg};
        PAFS_K_BIT: rdata_next = {31'h0000_0000,
          rdec.idx[3] ? pu_reg[rdec.idx[2:0]] : pac_reg[rdec.idx[2:0]]};
        default: begin
          rdata_next = 32'h0000_0000;
          rresp_next = RESP_SLVERR;
        end
      endcase
    end
    arready_next = ~rvalid_next;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_reg <= '0;
      for (int p = 0; p < NPORT; p++) begin
        dir_reg[p] <= (p == P11_IDX) ? RST_DIR_P11 : RST_DIR;
      end
      od_reg <= '0;
      pac_reg <= RST_PORT_ALT_CTRL; // R5
      pu_reg <= RST_PORT11_PULLUP; // R2
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= 32'h0000_0000;
      wstrb0_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end else begin
      latch_reg <= latch_next;
      dir_reg <= dir_next;
      od_reg <= od_next;
      pac_reg <= pac_next;
      pu_reg <= pu_next;
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb0_reg <= wstrb0_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign pin_o = pin_o_reg;
  assign pin_oe = pin_oe_reg;
  assign alt_in = alt_in_reg;
  assign port11_pullup_en = pu_out_reg;
  assign ext_wait_req = wait_reg;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  pafs_kind_t rkind_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) rkind_q <= PAFS_K_NONE;
    else if (s_axi_arvalid & arready_reg) rkind_q <= rdec.kind;
  end

  property p_pu_pin;
    @(posedge aclk) disable iff (!aresetn)
    $past(aresetn) |-> port11_pullup_en == $past(pu_reg[3:0]);
  endproperty
  a_pu_pin: assert property (p_pu_pin) else $error("pull-up output mismatch"); // R1

  property p_reset_vals;
    @(posedge aclk) $past(aresetn) && !aresetn |=> pu_reg == 8'h00 && pac_reg == 8'h00;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong"); // R5

  property p_pu_read_upper;
    @(posedge aclk) disable iff (!aresetn)
    $rose(rvalid_reg) && rkind_q == PAFS_K_PU |-> rdata_reg[31:4] == 28'h000_0000;
  endproperty
  a_pu_read_upper: assert property (p_pu_read_upper) else $error("pull-up upper bits"); // R2

  property p_byte_pac;
    @(posedge aclk) disable iff (!aresetn)
    do_write && wstrb0_reg && wdec.kind == PAFS_K_PAC
      |=> pac_reg == {7'h00, $past(wdata_reg[0])};
  endproperty
  a_byte_pac: assert property (p_byte_pac) else $error("byte write to control"); // R6

  property p_bit_pu;
    @(posedge aclk) disable iff (!aresetn)
    do_write && wstrb0_reg && wdec.kind == PAFS_K_BIT && wdec.idx == 4'ha
      |=> pu_reg[2] == $past(wdata_reg[0]) && $stable(pu_reg[1:0]);
  endproperty
  a_bit_pu: assert property (p_bit_pu) else $error("bit write to pull-up"); // R3

  property p_wait_gate;
    @(posedge aclk) disable iff (!aresetn)
    ext_wait_req |-> $past(pac_reg[WAIT_EN_BIT]) && pac_reg[7:1] == 7'h00;
  endproperty
  a_wait_gate: assert property (p_wait_gate) else $error("wait without enable"); // R18

  property p_oe_dir;
    @(posedge aclk) disable iff (!aresetn)
    $past(aresetn) |-> (pin_oe_reg[0] & $past(dir_reg[0])) == 8'h00;
  endproperty
  a_oe_dir: assert property (p_oe_dir) else $error("drive in input direction"); // R16

  property p_or_out;
    @(posedge aclk) disable iff (!aresetn)
    $past(aresetn) |-> pin_o_reg[3] == $past(latch_reg[3] | alt_out[3]);
  endproperty
  a_or_out: assert property (p_or_out) else $error("pin not latch or peripheral"); // R17

  property p_bresp_hold;
    @(posedge aclk) disable iff (!aresetn)
    bvalid_reg && !s_axi_bready |=> bvalid_reg && $stable(bresp_reg);
  endproperty
  a_bresp_hold: assert property (p_bresp_hold) else $error("write response dropped");

  property p_write_resp;
    @(posedge aclk) disable iff (!aresetn)
    s_axi_awvalid && awready_reg && s_axi_wvalid && wready_reg |-> ##2 bvalid_reg;
  endproperty
  a_write_resp: assert property (p_write_resp) else $error("write response late");

  c_bit_write: cover property (@(posedge aclk) do_write && wdec.kind == PAFS_K_BIT);
  c_wait: cover property (@(posedge aclk) $rose(ext_wait_req));
  c_bad_read: cover property (@(posedge aclk) rvalid_reg && rresp_reg == RESP_SLVERR);
endmodule
`default_nettype wire

// ---- tb/pafs_far.sv ----
// far-side model: pads with external drivers, port 11 pull-ups, peripheral outputs
// assumes pafs_top pin vectors and a free-running aclk
`default_nettype none
module pafs_far
  import pafs_pkg::*;
(
  input wire logic aclk,
  input wire logic [NPORT-1:0][7:0] pin_o,
  input wire logic [NPORT-1:0][7:0] pin_oe,
  input wire logic [3:0] port11_pullup_en,
  input wire logic [NPORT-1:0][7:0] ext_en,
  input wire logic [NPORT-1:0][7:0] ext_lvl,
  input wire logic [NPORT-1:0][7:0] periph_val,
  output logic [NPORT-1:0][7:0] pin_i,
  output logic [NPORT-1:0][7:0] alt_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic flip_reg = 1'b0;
  // ------------------------------------------------------------
  // pad resolution
  // ------------------------------------------------------------
  // a floating pad shows a changing pattern, never a held level
  always @(posedge aclk) flip_reg <= ~flip_reg;
  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      for (int b = 0; b < 8; b++) begin
        if (pin_oe[p][b]) pin_i[p][b] = pin_o[p][b];
        else if (ext_en[p][b]) pin_i[p][b] = ext_lvl[p][b];
        else if (p == P11_IDX && b < 4 && port11_pullup_en[b]) pin_i[p][b] = 1'b1;
        else pin_i[p][b] = flip_reg ^ 1'(b);
      end
    end
  end
  assign alt_out = periph_val;
endmodule
`default_nettype wire

// ---- tb/pafs_top_tb_top.sv ----
// self-checking bench for pafs_top: register access over axi4-lite and pin steering
// assumes pafs_far as the pad and peripheral side, default ADDR_W of 16
`default_nettype none
module pafs_top_tb_top;
  import pafs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] A_PAC = 16'(IDX_PORT_ALT_CTRL << 2);
  localparam logic [15:0] A_PU = 16'(IDX_PORT11_PULLUP << 2);
  localparam logic [15:0] A_LAT = 16'(IDX_LATCH_BASE << 2);
  localparam logic [15:0] A_DIR = 16'(IDX_DIR_BASE << 2);
  localparam logic [15:0] A_OD = 16'(IDX_OD_BASE << 2);
  localparam logic [15:0] A_PACB = 16'(IDX_BIT_BASE << 2);
  localparam logic [15:0] A_PUB = 16'((IDX_BIT_BASE + 8) << 2);
  localparam logic [15:0] A_BAD = 16'h3ffc;
  logic aclk, aresetn;
  logic [15:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, port11_pullup_en;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [NPORT-1:0][7:0] pin_i, pin_o, pin_oe, alt_out, alt_in, ext_en, ext_lvl, periph_val;
  logic ext_wait_req;
  int num_errors = 0;
  int check_count = 0;
  logic [7:0] rd;
  logic [1:0] rs;

  pafs_top pafs_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
    .alt_out(alt_out), .alt_in(alt_in), .port11_pullup_en(port11_pullup_en),
    .ext_wait_req(ext_wait_req));
  pafs_far pafs_far_inst (.aclk(aclk), .pin_o(pin_o), .pin_oe(pin_oe),
    .port11_pullup_en(port11_pullup_en), .ext_en(ext_en), .ext_lvl(ext_lvl),
    .periph_val(periph_val), .pin_i(pin_i), .alt_out(alt_out));

  // ------------------------------------------------------------
  // clock, checking and closing
  // ------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #(20 * 20000);
    num_errors++;
    $display("watchdog expired");
    final_report();
  end
  // ------------------------------------------------------------
  // axi4-lite master tasks, entered just after a rising edge
  // ------------------------------------------------------------
  task automatic axw(input logic [15:0] a, input logic [7:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'h1;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    r = 2'h3;
    while (n < 200) begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid === 1'b1 && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid === 1'b1 && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bready === 1'b1 && s_axi_bvalid === 1'b1) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        n = 1000;
      end
    end
    @(posedge aclk);
    if (n != 1000) chk("write response arrival", 0, 1);
  endtask
  task automatic axr(input logic [15:0] a, output logic [7:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (n < 200) begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid === 1'b1 && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rready === 1'b1 && s_axi_rvalid === 1'b1) begin
        d = s_axi_rdata[7:0];
        r = s_axi_rresp;
        chk("read upper bits", s_axi_rdata[31:8], 0);
        s_axi_rready <= 1'b0;
        n = 1000;
      end
    end
    @(posedge aclk);
    if (n != 1000) chk("read response arrival", 0, 1);
  endtask
  task automatic rd_chk(input string what, input logic [15:0] a, input logic [7:0] exp);
    axr(a, rd, rs);
    chk(what, rd, exp);
    chk("read response", rs, RESP_OKAY);
  endtask
  // pins follow registers a cycle late, inputs through a two-flop synchroniser
  task automatic settle();
    repeat (4) @(posedge aclk);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    rd_chk("pullup reset", A_PU, RST_PORT11_PULLUP);
    rd_chk("control reset", A_PAC, RST_PORT_ALT_CTRL);
    chk("pullup pins reset", port11_pullup_en, 0);
    chk("wait request reset", ext_wait_req, 0);
    chk("port 11 upper no drive", pin_oe[P11_IDX][7:4], 0);
    $display("test reset values done");
  endtask
  task automatic t_pullup();
    axw(A_PU, 8'hff, rs);
    chk("pullup write response", rs, RESP_OKAY);
    rd_chk("pullup masked", A_PU, 8'h0f);
    settle();
    chk("pullup pins all", port11_pullup_en, 4'hf);
    chk("pulled pad level", alt_in[P11_IDX][3:0], 4'hf);
    axw(A_PUB + 16'd8, 8'h00, rs);
    rd_chk("pullup after bit clear", A_PU, 8'h0b);
    rd_chk("pullup bit read", A_PUB + 16'd12, 8'h01);
    rd_chk("pullup high bit read", A_PUB + 16'd28, 8'h00);
    axw(A_PU, 8'h05, rs);
    settle();
    chk("pullup pins pattern", port11_pullup_en, 4'h5);
    $display("test pull-up register done");
  endtask
  task automatic t_wait();
    ext_en[P11_IDX] <= 8'h01;
    ext_lvl[P11_IDX] <= 8'h00;
    settle();
    chk("wait off", ext_wait_req, 0);
    axw(A_PAC, 8'hff, rs);
    rd_chk("control masked", A_PAC, 8'h01);
    settle();
    chk("wait on", ext_wait_req, 1);
    ext_lvl[P11_IDX] <= 8'h01;
    settle();
    chk("wait pin released", ext_wait_req, 0);
    ext_lvl[P11_IDX] <= 8'h00;
    axw(A_PACB, 8'h00, rs);
    rd_chk("control bit read", A_PACB, 8'h00);
    settle();
    chk("wait off again", ext_wait_req, 0);
    axw(A_PACB, 8'h01, rs);
    rd_chk("control after bit set", A_PAC, 8'h01);
    $display("test wait enable done");
  endtask
  task automatic t_pins();
    axw(A_LAT + 16'd8, 8'h81, rs);
    axw(A_DIR + 16'd8, 8'h00, rs);
    periph_val[2] <= 8'h5a;
    settle();
    chk("output enable", pin_oe[2], 8'hff);
    chk("latch or peripheral", pin_o[2], 8'hdb);
    axw(A_LAT + 16'd8, 8'h00, rs);
    settle();
    chk("peripheral alone", pin_o[2], 8'h5a);
    axw(A_DIR + 16'd8, 8'hff, rs);
    ext_en[2] <= 8'hff;
    ext_lvl[2] <= 8'h3c;
    ext_en[0] <= 8'hff;
    ext_lvl[0] <= 8'ha1;
    settle();
    chk("input no drive", pin_oe[2], 8'h00);
    chk("input sampled", alt_in[2], 8'h3c);
    chk("port 0 inputs", alt_in[0], 8'ha1);
    $display("test pin steering done");
  endtask
  task automatic t_unmapped();
    axw(A_BAD, 8'h55, rs);
    chk("unmapped write", rs, RESP_SLVERR);
    axr(A_BAD, rd, rs);
    chk("unmapped read", rs, RESP_SLVERR);
    rd_chk("control untouched", A_PAC, 8'h01);
    $display("test unmapped access done");
  endtask
  task automatic t_odrain();
    axw(A_OD, 8'h05, rs);
    axw(A_LAT + 16'd4, 8'h00, rs);
    axw(A_DIR + 16'd4, 8'h20, rs);
    periph_val[1] <= 8'h01;
    settle();
    chk("open-drain enable", pin_oe[1], 8'hde);
    chk("open-drain level", pin_o[1], 8'h00);
    rd_chk("open-drain read", A_OD, 8'h05);
    rd_chk("direction read", A_DIR + 16'd4, 8'h20);
    axw(A_DIR + 16'd4, 8'h21, rs);
    periph_val[1] <= 8'h00;
    settle();
    chk("serial input no drive", pin_oe[1], 8'hde);
    $display("test open-drain done");
  endtask
  task automatic t_midreset();
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk("pullup after reset", A_PU, RST_PORT11_PULLUP);
    rd_chk("control after reset", A_PAC, RST_PORT_ALT_CTRL);
    chk("pullup pins after reset", port11_pullup_en, 0);
    chk("wait after reset", ext_wait_req, 0);
    $display("test mid-run reset done");
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    ext_en = '0;
    ext_lvl = '0;
    periph_val = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_pullup();
    t_wait();
    t_pins();
    t_odrain();
    t_unmapped();
    t_midreset();
    final_report();
  end
endmodule
`default_nettype wire
